// [src/hca_top.sv]
// heater current alarms with multi-loop measurement sequencer
`timescale 1ns/1ns
module hca_top #(
    parameter int LOOPS = 3,
    parameter longint unsigned SLOT_CYCLES = hca_pkg::SLOT_CYC,
    parameter longint unsigned MINUTE_CYCLES = hca_pkg::MINUTE_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [1:0] IN_TYPE,
    input wire logic [13:0] SCALE_SET,
    input wire logic SCALE_WR,
    input wire logic [13:0] HIGH_SET,
    input wire logic HIGH_WR,
    input wire logic [13:0] LOW_SET,
    input wire logic LOW_WR,
    input wire logic SHORT_EN_SET,
    input wire logic SHORT_EN_WR,
    input wire logic [13:0] BUS_CUR_SET,
    input wire logic BUS_CUR_WR,
    input wire logic [3:0] PERIOD_SET,
    input wire logic PERIOD_WR,
    input wire logic [2:0] CAL_PHASE_SET,
    input wire logic CAL_PHASE_WR,
    input wire logic [13:0] CT_CUR,
    input wire logic CT_VALID,
    input wire logic [LOOPS-1:0] LOOP_DEMAND,
    output logic [LOOPS-1:0] HEAT_OUT,
    output logic [LOOPS-1:0] LOW_ALARM,
    output logic [LOOPS-1:0] HIGH_ALARM,
    output logic [LOOPS-1:0] SHORT_ALARM,
    output logic [LOOPS*14-1:0] LOOP_CUR,
    output logic [1:0] IN_TYPE_Q,
    output logic [13:0] SCALE_Q,
    output logic [13:0] HIGH_Q,
    output logic [13:0] LOW_Q,
    output logic SHORT_EN_Q,
    output logic [13:0] BUS_CUR_Q,
    output logic [3:0] PERIOD_Q,
    output logic [2:0] CAL_PHASE_Q
);
    ////////////////////////////////////////////////////////////////////////////
    // parameters
    logic [1:0] type_r;
    logic [13:0] scale_r;
    logic [13:0] high_r;
    logic [13:0] low_r;
    logic short_en_r;
    logic [13:0] bus_r;
    logic [3:0] period_r;
    logic [2:0] cal_r;
    logic type_chg;
    logic [13:0] scale_nxt;
    logic scale_ok;
    logic type_ok;

    assign type_ok = (IN_TYPE <= hca_pkg::IN_BUS);
    assign type_chg = type_ok && (IN_TYPE != type_r);
    assign scale_ok = (SCALE_SET >= hca_pkg::SCALE_MIN) && (SCALE_SET <= hca_pkg::SCALE_MAX);

    always_comb begin
        scale_nxt = scale_r;
        if (type_chg) begin
            scale_nxt = hca_pkg::SCALE_DEF;
        end else if (SCALE_WR && scale_ok) begin
            scale_nxt = SCALE_SET;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            type_r <= hca_pkg::IN_CT;
            scale_r <= hca_pkg::SCALE_DEF;
        end else begin
            if (type_ok) begin
                type_r <= IN_TYPE;
            end
            scale_r <= scale_nxt;
        end
    end

    // thresholds out of range of the new scale fall back: high to the new scale, low to zero
    always_ff @(posedge CLK) begin
        if (SRST) begin
            high_r <= hca_pkg::SCALE_DEF;
            low_r <= '0;
        end else begin
            if (HIGH_WR && HIGH_SET <= scale_nxt) begin
                high_r <= HIGH_SET;
            end else if (high_r > scale_nxt || high_r == scale_r) begin
                high_r <= scale_nxt;
            end
            if (LOW_WR && LOW_SET <= scale_nxt) begin
                low_r <= LOW_SET;
            end else if (low_r > scale_nxt) begin
                low_r <= '0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            short_en_r <= 1'b1;
            bus_r <= '0;
            period_r <= hca_pkg::PERIOD_DEF;
            cal_r <= 3'h1;
        end else begin
            if (SHORT_EN_WR) begin
                short_en_r <= SHORT_EN_SET;
            end
            if (type_chg) begin
                bus_r <= '0;
            end else if (BUS_CUR_WR && BUS_CUR_SET <= scale_r) begin
                bus_r <= BUS_CUR_SET;
            end else if (bus_r > scale_nxt) begin
                bus_r <= '0;
            end
            if (PERIOD_WR && PERIOD_SET >= hca_pkg::PERIOD_MIN
                    && PERIOD_SET <= hca_pkg::PERIOD_MAX) begin
                period_r <= PERIOD_SET;
            end
            if (CAL_PHASE_WR && CAL_PHASE_SET >= 3'h1 && CAL_PHASE_SET <= 3'h5) begin
                cal_r <= CAL_PHASE_SET;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: one output per slot, shared transformer sampled at slot end
    hca_pkg::hca_seq_e st_r;
    logic [31:0] slot_cnt_r;
    logic [31:0] min_cnt_r;
    logic [3:0] min_left_r;
    logic [1:0] loop_r;
    logic slot_end;
    logic sample_r;
    logic [LOOPS-1:0] heat_d_r;
    logic [13:0] ct_r;

    // three slots of SLOT_CYCLES keep a full pass inside two seconds
    assign slot_end = (st_r == hca_pkg::SEQ_SLOT) && (slot_cnt_r == 32'(SLOT_CYCLES - 1));

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ct_r <= '0;
        end else if (CT_VALID) begin
            ct_r <= CT_CUR;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_r <= hca_pkg::SEQ_IDLE;
            slot_cnt_r <= '0;
            min_cnt_r <= '0;
            min_left_r <= '0;
            loop_r <= '0;
        end else begin
            case (st_r)
                hca_pkg::SEQ_IDLE: begin
                    st_r <= hca_pkg::SEQ_SLOT;
                    slot_cnt_r <= '0;
                    loop_r <= '0;
                end
                hca_pkg::SEQ_SLOT: begin
                    slot_cnt_r <= slot_cnt_r + 32'h1;
                    if (slot_end) begin
                        slot_cnt_r <= '0;
                        if (loop_r == 2'(LOOPS - 1)) begin
                            st_r <= hca_pkg::SEQ_WAIT;
                            min_cnt_r <= '0;
                            min_left_r <= period_r;
                        end else begin
                            loop_r <= loop_r + 2'h1;
                        end
                    end
                end
                hca_pkg::SEQ_WAIT: begin
                    min_cnt_r <= min_cnt_r + 32'h1;
                    if (min_cnt_r == 32'(MINUTE_CYCLES - 1)) begin
                        min_cnt_r <= '0;
                        min_left_r <= min_left_r - 4'h1;
                        if (min_left_r == 4'h1) begin
                            st_r <= hca_pkg::SEQ_IDLE;
                        end
                    end
                end
                default: begin
                    st_r <= hca_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // measuring slot overrides demand: only the selected loop drives
    always_ff @(posedge CLK) begin
        if (SRST) begin
            HEAT_OUT <= '0;
        end else if (st_r == hca_pkg::SEQ_SLOT) begin
            HEAT_OUT <= LOOPS'(1) << loop_r;
        end else begin
            HEAT_OUT <= LOOP_DEMAND;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            sample_r <= 1'b0;
            heat_d_r <= '0;
        end else begin
            sample_r <= slot_end || (type_r == hca_pkg::IN_BUS && BUS_CUR_WR);
            heat_d_r <= HEAT_OUT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // high and low alarms per loop, evaluated on each sample; shorted-drive alarm on each off-state reading with the ct input type
    logic [13:0] cur;
    logic [20:0] off_x100;
    logic [20:0] trip_lvl;
    logic [20:0] rel_lvl;
    logic short_ok;
    logic [1:0] samp_loop_r;

    assign cur = (type_r == hca_pkg::IN_BUS) ? bus_r : ct_r;
    assign off_x100 = 21'(cur) * 21'(hca_pkg::PCT_FULL);
    assign trip_lvl = 21'(scale_r) * 21'(hca_pkg::SHORT_ON_PCT);
    assign rel_lvl = 21'(scale_r) * 21'(hca_pkg::SHORT_OFF_PCT);
    assign short_ok = short_en_r && (type_r == hca_pkg::IN_CT);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            samp_loop_r <= '0;
        end else if (slot_end) begin
            samp_loop_r <= loop_r;
        end
    end

    genvar g;
    generate
        for (g = 0; g < LOOPS; g = g + 1) begin : g_loop
            logic sel;
            logic heat_on;
            assign sel = sample_r && (samp_loop_r == 2'(g));
            assign heat_on = LOOP_DEMAND[g];
            always_ff @(posedge CLK) begin
                if (SRST) begin
                    HIGH_ALARM[g] <= 1'b0;
                    LOW_ALARM[g] <= 1'b0;
                    LOOP_CUR[g*14 +: 14] <= '0;
                end else if (sel) begin
                    LOOP_CUR[g*14 +: 14] <= cur;
                    if (high_r == scale_r) begin
                        HIGH_ALARM[g] <= 1'b0;
                    end else if (cur > high_r) begin
                        HIGH_ALARM[g] <= 1'b1;
                    end else if (15'(cur) + 15'(hca_pkg::HYST_DA) <= 15'(high_r)) begin
                        HIGH_ALARM[g] <= 1'b0;
                    end
                    if (low_r == '0) begin
                        LOW_ALARM[g] <= 1'b0;
                    end else if (cur < low_r) begin
                        LOW_ALARM[g] <= 1'b1;
                    end else if (15'(cur) >= 15'(low_r) + 15'(hca_pkg::HYST_DA)) begin
                        LOW_ALARM[g] <= 1'b0;
                    end
                end
            end
            // off-state samples: the reading lags the outputs by one cycle, so both must be off
            always_ff @(posedge CLK) begin
                if (SRST) begin
                    SHORT_ALARM[g] <= 1'b0;
                end else if (!short_ok) begin
                    SHORT_ALARM[g] <= 1'b0;
                end else if (CT_VALID && !heat_on && HEAT_OUT == '0 && heat_d_r == '0) begin
                    if (21'(CT_CUR) * 21'(hca_pkg::PCT_FULL) > trip_lvl) begin
                        SHORT_ALARM[g] <= 1'b1;
                    end else if (21'(CT_CUR) * 21'(hca_pkg::PCT_FULL) < rel_lvl) begin
                        SHORT_ALARM[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (SRST) begin
            IN_TYPE_Q <= hca_pkg::IN_CT;
            SCALE_Q <= hca_pkg::SCALE_DEF;
            HIGH_Q <= hca_pkg::SCALE_DEF;
            LOW_Q <= '0;
            SHORT_EN_Q <= 1'b1;
            BUS_CUR_Q <= '0;
            PERIOD_Q <= hca_pkg::PERIOD_DEF;
            CAL_PHASE_Q <= 3'h1;
        end else begin
            IN_TYPE_Q <= type_r;
            SCALE_Q <= scale_r;
            HIGH_Q <= high_r;
            LOW_Q <= low_r;
            SHORT_EN_Q <= short_en_r;
            BUS_CUR_Q <= bus_r;
            PERIOD_Q <= period_r;
            CAL_PHASE_Q <= cal_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_slot_onehot: assert property (@(posedge CLK) disable iff (SRST)
        st_r == hca_pkg::SEQ_SLOT |=> $onehot(HEAT_OUT))
        else $error("more than one output on while measuring");
    a_bus_clear: assert property (@(posedge CLK) disable iff (SRST)
        type_chg |=> bus_r == '0)
        else $error("bus current not cleared on type change");
    a_short_gated: assert property (@(posedge CLK) disable iff (SRST)
        type_r != hca_pkg::IN_CT |=> SHORT_ALARM == '0)
        else $error("shorted-drive alarm outside ct input type");
    a_high_range: assert property (@(posedge CLK) disable iff (SRST)
        high_r <= scale_r)
        else $error("high threshold above scale");
    a_short_en_reset: assert property (@(posedge CLK)
        $fell(SRST) |-> short_en_r)
        else $error("shorted-drive enable not set after reset");
    a_scale_range: assert property (@(posedge CLK) disable iff (SRST)
        scale_r >= hca_pkg::SCALE_MIN && scale_r <= hca_pkg::SCALE_MAX)
        else $error("scale out of range");
    a_period_range: assert property (@(posedge CLK) disable iff (SRST)
        period_r >= hca_pkg::PERIOD_MIN && period_r <= hca_pkg::PERIOD_MAX)
        else $error("period out of range");
    a_low_off: assert property (@(posedge CLK) disable iff (SRST)
        sample_r && low_r == '0 |=> LOW_ALARM[samp_loop_r] == 1'b0)
        else $error("low alarm active while disabled");
    c_pass_done: cover property (@(posedge CLK) st_r == hca_pkg::SEQ_WAIT);
    c_high_trip: cover property (@(posedge CLK) HIGH_ALARM != '0);
    c_short_trip: cover property (@(posedge CLK) SHORT_ALARM != '0);
endmodule : hca_top

// [pkg/hca_pkg.sv]
// constants and types for the heater current supervision block
package hca_pkg;
    // current values are in 0.1 A units
    localparam int CUR_W = 14;
    localparam logic [13:0] HYST_DA = 14'h0005;
    localparam logic [13:0] SCALE_MIN = 14'h0064;
    localparam logic [13:0] SCALE_MAX = 14'h2710;
    localparam logic [13:0] SCALE_DEF = 14'h01f4;
    localparam logic [6:0] SHORT_ON_PCT = 7'h05;
    localparam logic [6:0] SHORT_OFF_PCT = 7'h03;
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [1:0] IN_CT = 2'h0;
    localparam logic [1:0] IN_THYR = 2'h1;
    localparam logic [1:0] IN_BUS = 2'h2;
    localparam logic [3:0] PERIOD_MIN = 4'h1;
    localparam logic [3:0] PERIOD_MAX = 4'hf;
    localparam logic [3:0] PERIOD_DEF = 4'h1;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned SLOT_MS = 600;
    localparam longint unsigned SLOT_CYC = longint'(CLK_HZ) / 1000 * SLOT_MS;
    localparam int unsigned MINUTE_S = 60;
    localparam longint unsigned MINUTE_CYC = longint'(CLK_HZ) * MINUTE_S;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SLOT = 2'b01,
        SEQ_WAIT = 2'b10
    } hca_seq_e;
endpackage : hca_pkg

// [dv/hca_ct_model.sv]
// shared current transformer model seen through the heater outputs
`timescale 1ns/1ns
module hca_ct_model (
    input wire logic clk,
    input wire logic [2:0] heat,
    input wire logic [41:0] on_cur,
    input wire logic [13:0] leak_cur,
    output logic [13:0] ct_cur,
    output logic ct_valid
);
    logic [1:0] div_r = 2'h0;
    logic [13:0] sum;
    // one reading covers every heater that is on, leakage when all are off
    always_comb begin
        sum = (heat == 3'h0) ? leak_cur : 14'h0;
        for (int i = 0; i < 3; i++) begin
            if (heat[i]) begin
                sum = sum + on_cur[i*14 +: 14];
            end
        end
    end
    // a reading every fourth cycle; the data lines toggle between readings
    always_ff @(posedge clk) begin
        div_r <= div_r + 2'h1;
        ct_valid <= (div_r == 2'h3);
        ct_cur <= (div_r == 2'h3) ? sum : ~ct_cur;
    end
endmodule : hca_ct_model

// [dv/hca_top_tb_top.sv]
// self-checking bench for the heater current alarms
`timescale 1ns/1ns
module hca_top_tb_top;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic [1:0] IN_TYPE = 2'h0;
    logic [13:0] SCALE_SET = 14'h0, HIGH_SET = 14'h0, LOW_SET = 14'h0, BUS_CUR_SET = 14'h0;
    logic SCALE_WR = 1'b0, HIGH_WR = 1'b0, LOW_WR = 1'b0, SHORT_EN_WR = 1'b0, BUS_CUR_WR = 1'b0;
    logic SHORT_EN_SET = 1'b0, PERIOD_WR = 1'b0, CAL_PHASE_WR = 1'b0;
    logic [3:0] PERIOD_SET = 4'h0;
    logic [2:0] CAL_PHASE_SET = 3'h0;
    logic [13:0] CT_CUR, SCALE_Q, HIGH_Q, LOW_Q, BUS_CUR_Q, leak = 14'h0;
    logic CT_VALID, SHORT_EN_Q;
    logic [2:0] LOOP_DEMAND = 3'h0;
    logic [2:0] HEAT_OUT, LOW_ALARM, HIGH_ALARM, SHORT_ALARM, CAL_PHASE_Q;
    logic [41:0] LOOP_CUR, on_cur = 42'h0;
    logic [1:0] IN_TYPE_Q;
    logic [3:0] PERIOD_Q;
    int n_mismatch = 0, compares = 0, tick = 0, seed = 49;

    always #2 CLK = ~CLK;

    hca_top #(.LOOPS(3), .SLOT_CYCLES(20), .MINUTE_CYCLES(50)) dut (.*);
    hca_ct_model ct (.clk(CLK), .heat(HEAT_OUT), .on_cur(on_cur), .leak_cur(leak),
        .ct_cur(CT_CUR), .ct_valid(CT_VALID));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    always @(posedge CLK) begin
        tick++;
        if (tick == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask : cyc

    // sel: 0 scale, 1 high, 2 low, 3 shorted enable, 4 bus current, 5 period, 6 cal phase
    task automatic wr(input int sel, input logic [13:0] v);
        SCALE_SET <= v;
        HIGH_SET <= v;
        LOW_SET <= v;
        SHORT_EN_SET <= v[0];
        BUS_CUR_SET <= v;
        PERIOD_SET <= v[3:0];
        CAL_PHASE_SET <= v[2:0];
        {CAL_PHASE_WR, PERIOD_WR, BUS_CUR_WR, SHORT_EN_WR, LOW_WR, HIGH_WR, SCALE_WR} <= 7'(1 << sel);
        cyc(1);
        {CAL_PHASE_WR, PERIOD_WR, BUS_CUR_WR, SHORT_EN_WR, LOW_WR, HIGH_WR, SCALE_WR} <= 7'h0;
        cyc(3);
    endtask : wr

    // returns just after the last measurement slot of a pass
    task automatic wait_pass;
        while (HEAT_OUT !== 3'h4) @(posedge CLK);
        while (HEAT_OUT === 3'h4) @(posedge CLK);
    endtask : wait_pass

    function automatic logic hi_x(input logic p, input logic [13:0] c, input logic [13:0] t);
        return p ? (c > t - 14'h5) : (c > t);
    endfunction : hi_x

    function automatic logic lo_x(input logic p, input logic [13:0] c, input logic [13:0] t);
        return p ? (c < t + 14'h5) : (c < t);
    endfunction : lo_x

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [13:0] c [3];
        logic [13:0] cor [8];
        logic ph [3];
        logic pl [3];
        logic [31:0] r;
        int n;
        cor = '{14'h191, 14'h190, 14'h18c, 14'h18b, 14'h0c7, 14'h0c8, 14'h0cc, 14'h0cd};
        ph = '{1'b0, 1'b0, 1'b0};
        pl = '{1'b0, 1'b0, 1'b0};
        cyc(10);
        SRST <= 1'b0;
        cyc(3);
        chk(SCALE_Q, 14'h01f4);
        chk(HIGH_Q, 14'h01f4);
        chk({13'h0, SHORT_EN_Q}, 14'h1);
        chk({10'h0, PERIOD_Q}, 14'h1);
        chk(BUS_CUR_Q, 14'h0);
        for (int l = 0; l < 3; l++) begin
            cyc(l == 0 ? 10 : 20);
            chk({11'h0, HEAT_OUT}, 14'(1 << l));
        end
        // idle gap between passes is one heater period
        while (HEAT_OUT === 3'h4) @(posedge CLK);
        n = 0;
        while (HEAT_OUT === 3'h0) begin
            @(posedge CLK);
            n++;
        end
        chk({13'h0, n >= 47 && n <= 53}, 14'h1);
        wr(2, 14'h0c8);
        wr(1, 14'h190);
        wait_pass;
        for (int it = 0; it < 14; it++) begin
            for (int l = 0; l < 3; l++) begin
                r = $random(seed);
                c[l] = (it == 0) ? 14'h12c : r[4] ? cor[r[2:0]] : 14'(r[31:8] % 501);
            end
            on_cur <= {c[2], c[1], c[0]};
            wait_pass;
            cyc(4);
            for (int l = 0; l < 3; l++) begin
                ph[l] = hi_x(ph[l], c[l], 14'h190);
                pl[l] = lo_x(pl[l], c[l], 14'h0c8);
                chk({13'h0, HIGH_ALARM[l]}, {13'h0, ph[l]});
                chk({13'h0, LOW_ALARM[l]}, {13'h0, pl[l]});
                chk({13'h0, SHORT_ALARM[l]}, 14'h0);
            end
        end
        wr(1, 14'h0320);
        chk(HIGH_Q, 14'h0190);
        wr(1, 14'h01f4);
        wr(0, 14'h02bc);
        chk(HIGH_Q, 14'h02bc);
        wr(2, 14'h0);
        on_cur <= {14'h0, 14'h02bd, 14'h0};
        wait_pass;
        cyc(4);
        chk({11'h0, HIGH_ALARM | LOW_ALARM}, 14'h0);
        wr(5, 14'hf);
        wait_pass;
        // leakage against 5 and 3 percent of a 70.0 A scale
        for (int k = 0; k < 4; k++) begin
            leak <= (k == 0) ? 14'h23 : (k == 1) ? 14'h24 : (k == 2) ? 14'h15 : 14'h14;
            cyc(12);
            chk({13'h0, SHORT_ALARM != 3'h0}, {13'h0, k == 1 || k == 2});
        end
        leak <= 14'h24;
        wr(3, 14'h0);
        cyc(12);
        chk({11'h0, SHORT_ALARM}, 14'h0);
        wr(3, 14'h1);
        cyc(12);
        chk({13'h0, SHORT_ALARM != 3'h0}, 14'h1);
        IN_TYPE <= 2'h1;
        cyc(12);
        chk({11'h0, SHORT_ALARM}, 14'h0);
        chk(SCALE_Q, 14'h01f4);
        wr(0, 14'h0063);
        chk(SCALE_Q, 14'h01f4);
        IN_TYPE <= 2'h2;
        leak <= 14'h0;
        wr(1, 14'h0190);
        wr(4, 14'h01c2);
        chk(BUS_CUR_Q, 14'h01c2);
        chk({13'h0, HIGH_ALARM != 3'h0}, 14'h1);
        wr(4, 14'h01f5);
        chk(BUS_CUR_Q, 14'h01c2);
        IN_TYPE <= 2'h0;
        cyc(3);
        chk(BUS_CUR_Q, 14'h0);
        chk({11'h0, SHORT_ALARM}, 14'h0);
        wr(5, 14'h0);
        chk({10'h0, PERIOD_Q}, 14'hf);
        wr(6, 14'h5);
        wr(6, 14'h6);
        wr(6, 14'h0);
        chk({11'h0, CAL_PHASE_Q}, 14'h5);
        close_out();
    end
endmodule : hca_top_tb_top
